// [bsp_cfg.svh]
`ifndef BSP_CFG_SVH
`define BSP_CFG_SVH
// Printed register indices (byte address = 4 * index)
`define BSP_IDX_STOP_HIGH 8'h5E
`define BSP_IDX_STOP_LOW 8'h5F
`define BSP_IDX_SCHED_DATA 8'h68
`define BSP_IDX_SECTOR_STATUS 8'h69
`define BSP_IDX_CONTROL 8'h80
`define BSP_IDX_POINTERS 8'h81
`define BSP_IDX_STATUS 8'h82
// Reset values
`define BSP_STOP_HIGH_RST 8'h01
`define BSP_STOP_LOW_RST 8'hFF
// Control register fields
`define BSP_CTL_BM_RESET 0
`define BSP_CTL_AUTO_INC 1
`define BSP_CTL_OE_DISABLE 2
`define BSP_CTL_XFER_START 3
`define BSP_CTL_POLARITY 4
`define BSP_CTL_AUTO_CMD 5
// Status register fields
`define BSP_ST_XFER_DONE 0
`define BSP_ST_BYTE_READY 7
// Sector status fields
`define BSP_SS_END_TRACK 0
`define BSP_SS_DEFECT 1
`define BSP_SS_HOST_RESET 2
`define BSP_SS_POLARITY 3
// Last count of the buffer memory cycle, which lasts three clocks
`define BSP_MEM_CYCLES 3'h2
`endif

// [bsp_pkg.sv]
package bsp_pkg;
  typedef enum logic [1:0] {
    BSP_IDLE = 2'b00,
    BSP_READ = 2'b01,
    BSP_WRITE = 2'b10,
    BSP_STEP = 2'b11
  } bsp_sched_type;
endpackage : bsp_pkg

// [bsp_top.sv]
// The APB slave port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
`include "bsp_cfg.svh"
// Behaviour
// [R1] Stop high resets to 01H
// [R2] Stop low resets to FFH
// [R3] Pointer match sets done, halts transfer
// [R4] Stop high write restarts while start set
// [R5] Auto-command reloads stop pointer 01FFH
// [R6] Scheduled data register cleared on resets
// [R7] Access memory at pointer, or switches
// [R8] Auto-increment disk pointer after access
// [R9] Software checks ready before writing
// [R10] Ready low until write and step done
// [R11] Read returns previous byte, launches fetch
// [R12] Software primes, waits, reads again
// [R13] Software waits for switches to settle
// [R14] End-of-track flag set, clear on read
// [R15] Defect flag set, clear on read
// [R16] Host reset bit shows live pin
// [R17] Polarity bit mirrors control setting
// [R18] Sector status cleared, upper bits zero
// [R19] Strobe write increments sector count
// [R20] Manager reset bit holds registers reset
// [R21] Host pointer cleared by auto-command
// [R22] Full 16-bit stop comparison
// [R23] Flags clear after read data captured
module bsp_top (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic host_step,
  input wire logic id_end_of_track,
  input wire logic id_defect,
  input wire logic host_reset_in,
  input wire logic read_reference_clock,
  output logic [15:0] host_address_pointer,
  output logic host_transfer_active,
  output logic [15:0] buffer_addr,
  output logic [7:0] buffer_wdata,
  output logic [7:0] buffer_wdata_oe_n,
  input wire logic [7:0] buffer_rdata,
  output logic buffer_we_n,
  output logic buffer_output_enable_n,
  output logic [7:0] sector_count
);
  import bsp_pkg::*;

  //----------------------------------------
  // Bus decode
  //----------------------------------------
  // Each register is one aligned word at four times its index
  // Low address bits must be zero, upper bits must be clear
  // Side effects happen in the setup cycle only
  // The access cycle just presents the answer
  function automatic logic hit(input logic [31:0] a, input logic [7:0] idx);
    hit = (a[31:10] == 22'h0) && (a[9:2] == idx) && (a[1:0] == 2'h0);
  endfunction : hit

  logic setup;
  logic wr;
  logic rd;
  logic [7:0] wbyte;
  assign setup = psel && !penable;
  assign wr = setup && pwrite;
  assign rd = setup && !pwrite;
  assign wbyte = pwdata[7:0];

  // One select per register word
  logic sel_stop_high;
  logic sel_stop_low;
  logic sel_sched;
  logic sel_sector;
  logic sel_control;
  logic sel_pointers;
  logic sel_status;
  assign sel_stop_high = hit(paddr, `BSP_IDX_STOP_HIGH);
  assign sel_stop_low = hit(paddr, `BSP_IDX_STOP_LOW);
  assign sel_sched = hit(paddr, `BSP_IDX_SCHED_DATA);
  assign sel_sector = hit(paddr, `BSP_IDX_SECTOR_STATUS);
  assign sel_control = hit(paddr, `BSP_IDX_CONTROL);
  assign sel_pointers = hit(paddr, `BSP_IDX_POINTERS);
  assign sel_status = hit(paddr, `BSP_IDX_STATUS);

  // Anything outside the map is refused with an error
  logic mapped;
  assign mapped = sel_stop_high || sel_stop_low || sel_sched || sel_sector
    || sel_control || sel_pointers || sel_status;

  //----------------------------------------
  // Control register
  //----------------------------------------
  logic [5:0] control;
  logic bm_reset;
  logic auto_cmd;
  assign bm_reset = control[`BSP_CTL_BM_RESET];
  assign auto_cmd = wr && hit(paddr, `BSP_IDX_CONTROL) && wbyte[`BSP_CTL_AUTO_CMD];

  // Chip reset leaves the manager in reset until software clears bit 0
  // Auto-command is a write-only pulse, never stored
  // Manager reset bit set by chip reset; auto-command bit self-clears
  always_ff @(posedge clk) begin
    if (!resetn) begin
      control <= 6'h01; // [R20]
    end else if (wr && hit(paddr, `BSP_IDX_CONTROL)) begin
      control <= {1'b0, wbyte[4:0]};
    end
  end

  //----------------------------------------
  // Stop pointer and host pointer
  //----------------------------------------
  logic [7:0] stop_pointer_high;
  logic [7:0] stop_pointer_low;
  logic [15:0] transfer_stop_pointer;
  logic stop_high_write;
  logic host_transfer_done;
  assign transfer_stop_pointer = {stop_pointer_high, stop_pointer_low};
  assign stop_high_write = wr && hit(paddr, `BSP_IDX_STOP_HIGH);

  // Both bytes reload together on any reset or auto-command
  // Software writes one byte at a time
  // Stop pointer bytes
  always_ff @(posedge clk) begin
    if (!resetn || bm_reset || auto_cmd) begin
      stop_pointer_high <= `BSP_STOP_HIGH_RST; // [R1] [R5] [R20]
      stop_pointer_low <= `BSP_STOP_LOW_RST; // [R2] [R5]
    end else begin
      if (stop_high_write) begin
        stop_pointer_high <= wbyte;
      end
      if (wr && hit(paddr, `BSP_IDX_STOP_LOW)) begin
        stop_pointer_low <= wbyte;
      end
    end
  end

  // Host pointer advances per host byte while transfer runs
  always_ff @(posedge clk) begin
    if (!resetn || bm_reset || auto_cmd) begin
      host_address_pointer <= 16'h0000; // [R21]
    end else if (wr && hit(paddr, `BSP_IDX_POINTERS)) begin
      host_address_pointer <= pwdata[31:16];
    end else if (host_step && host_transfer_active) begin
      host_address_pointer <= host_address_pointer + 16'h0001; // [R21]
    end
  end

  // Match check wins over a restart in the same cycle
  // Done stays set until a new transfer starts
  // Clearing the start bit stops the run without setting done
  // Transfer run and done flag
  always_ff @(posedge clk) begin
    if (!resetn || bm_reset) begin
      host_transfer_active <= 1'b0;
      host_transfer_done <= 1'b0;
    end else if (host_transfer_active
                 && host_address_pointer == transfer_stop_pointer) begin
      host_transfer_active <= 1'b0; // [R3] [R22]
      host_transfer_done <= 1'b1; // [R3]
    end else if ((stop_high_write || (wr && hit(paddr, `BSP_IDX_CONTROL)
                  && wbyte[`BSP_CTL_XFER_START] && !control[`BSP_CTL_XFER_START]))
                 && (control[`BSP_CTL_XFER_START] || !stop_high_write)) begin
      host_transfer_active <= 1'b1; // [R4]
      host_transfer_done <= 1'b0;
    end else if (wr && hit(paddr, `BSP_IDX_CONTROL) && !wbyte[`BSP_CTL_XFER_START]) begin
      host_transfer_active <= 1'b0;
    end
  end

  //----------------------------------------
  // Scheduled buffer access
  //----------------------------------------
  bsp_sched_type state;
  logic [2:0] mem_count;
  logic [7:0] sched_data;
  logic [15:0] disk_address_pointer;
  logic byte_ready;
  logic sched_hit;
  assign sched_hit = hit(paddr, `BSP_IDX_SCHED_DATA);
  assign byte_ready = (state == BSP_IDLE); // [R10]

  // One access at a time; requests while busy are ignored
  // Busy covers the memory cycle and the pointer step
  // Byte ready is simply the idle state
  // Scheduler sequence
  always_ff @(posedge clk) begin
    if (!resetn || bm_reset) begin
      state <= BSP_IDLE;
      mem_count <= 3'h0;
    end else begin
      unique case (state)
        BSP_IDLE: begin
          mem_count <= 3'h0;
          if (wr && sched_hit) begin
            state <= BSP_WRITE;
          end else if (rd && sched_hit) begin
            state <= BSP_READ; // [R11]
          end
        end
        BSP_READ, BSP_WRITE: begin
          mem_count <= mem_count + 3'h1;
          if (mem_count == `BSP_MEM_CYCLES) begin
            state <= BSP_STEP;
          end
        end
        BSP_STEP: begin
          state <= BSP_IDLE; // [R10]
        end
      endcase
    end
  end

  // A read returns this latch, then refills it from the buffer
  // Data latch: write value, or byte fetched at end of a read
  always_ff @(posedge clk) begin
    if (!resetn || bm_reset) begin
      sched_data <= 8'h00; // [R6]
    end else if (state == BSP_IDLE && wr && sched_hit) begin
      sched_data <= wbyte;
    end else if (state == BSP_READ && mem_count == `BSP_MEM_CYCLES) begin
      sched_data <= buffer_rdata; // [R7] switches when output enable is off
    end
  end

  // Software load wins over the automatic step
  // Disk pointer: loaded by software, stepped after an access
  always_ff @(posedge clk) begin
    if (!resetn || bm_reset) begin
      disk_address_pointer <= 16'h0000;
    end else if (wr && hit(paddr, `BSP_IDX_POINTERS)) begin
      disk_address_pointer <= pwdata[15:0];
    end else if (state == BSP_STEP && control[`BSP_CTL_AUTO_INC]) begin
      disk_address_pointer <= disk_address_pointer + 16'h0001; // [R8]
    end
  end

  // Buffer address follows the disk pointer one cycle late
  always_ff @(posedge clk) begin
    if (!resetn || bm_reset) begin
      buffer_addr <= 16'h0000;
    end else begin
      buffer_addr <= disk_address_pointer; // [R7]
    end
  end

  // Write data comes from the latch
  always_ff @(posedge clk) begin
    if (!resetn || bm_reset) begin
      buffer_wdata <= 8'h00;
    end else begin
      buffer_wdata <= sched_data;
    end
  end

  // Data pins driven for the whole write, so they settle before the strobe
  always_ff @(posedge clk) begin
    if (!resetn || bm_reset) begin
      buffer_wdata_oe_n <= 8'hFF;
    end else begin
      buffer_wdata_oe_n <= (state == BSP_WRITE) ? 8'h00 : 8'hFF;
    end
  end

  // Write strobe skips the first write cycle
  always_ff @(posedge clk) begin
    if (!resetn || bm_reset) begin
      buffer_we_n <= 1'b1;
    end else begin
      buffer_we_n <= !(state == BSP_WRITE && mem_count != 3'h0);
    end
  end

  // Memory output enable; kept off to read the switches
  always_ff @(posedge clk) begin
    if (!resetn || bm_reset) begin
      buffer_output_enable_n <= 1'b1;
    end else begin
      buffer_output_enable_n <= !(state == BSP_READ
                                  && !control[`BSP_CTL_OE_DISABLE]); // [R7] [R13]
    end
  end

  //----------------------------------------
  // Sector status and count
  //----------------------------------------
  logic end_of_track;
  logic defect;
  logic status_read;
  assign status_read = rd && hit(paddr, `BSP_IDX_SECTOR_STATUS);

  // Flags are copied to read data in setup, then cleared
  // A new event in the read cycle wins, so nothing is lost

  // End-of-track flag
  always_ff @(posedge clk) begin
    if (!resetn) begin
      end_of_track <= 1'b0; // [R18]
    end else begin
      end_of_track <= id_end_of_track || (end_of_track && !status_read); // [R14] [R23]
    end
  end

  // Defect flag
  always_ff @(posedge clk) begin
    if (!resetn) begin
      defect <= 1'b0; // [R18]
    end else begin
      defect <= id_defect || (defect && !status_read); // [R15] [R23]
    end
  end

  // Same word as sector status: reads see flags, writes step the count
  // Strobe increments count when reference clock is running
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sector_count <= 8'h00;
    end else if (wr && hit(paddr, `BSP_IDX_SECTOR_STATUS) && read_reference_clock) begin
      sector_count <= sector_count + 8'h01; // [R19]
    end
  end

  //----------------------------------------
  // APB answer
  //----------------------------------------
  logic [7:0] sector_status;
  assign sector_status = {4'h0, control[`BSP_CTL_POLARITY], host_reset_in,
                          defect, end_of_track}; // [R16] [R17] [R18]

  // Every transfer gets exactly one access cycle, no wait states
  // Read data stands until the next read setup
  // Refused reads return zero
  // Read data captured at setup; answer in the access phase
  always_ff @(posedge clk) begin
    if (!resetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      if (rd) begin
        if (hit(paddr, `BSP_IDX_STOP_HIGH)) begin
          prdata <= {24'h0, stop_pointer_high};
        end else if (hit(paddr, `BSP_IDX_STOP_LOW)) begin
          prdata <= {24'h0, stop_pointer_low};
        end else if (sched_hit) begin
          prdata <= {24'h0, sched_data}; // [R11]
        end else if (hit(paddr, `BSP_IDX_SECTOR_STATUS)) begin
          prdata <= {24'h0, sector_status}; // [R23]
        end else if (hit(paddr, `BSP_IDX_CONTROL)) begin
          prdata <= {26'h0, control};
        end else if (hit(paddr, `BSP_IDX_POINTERS)) begin
          prdata <= {host_address_pointer, disk_address_pointer};
        end else if (hit(paddr, `BSP_IDX_STATUS)) begin
          prdata <= {24'h0, byte_ready, 6'h0, host_transfer_done}; // [R3] [R10]
        end else begin
          prdata <= 32'h0000_0000;
        end
      end
    end
  end
endmodule : bsp_top
`default_nettype wire

// [bsp_checker.sv]
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------
// Port checker for the buffer access block
// ------------------------------------
module bsp_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic host_step,
  input wire logic host_reset_in,
  input wire logic read_reference_clock,
  input wire logic [15:0] host_address_pointer,
  input wire logic host_transfer_active,
  input wire logic buffer_we_n,
  input wire logic [7:0] buffer_wdata_oe_n,
  input wire logic [7:0] sector_count
);
  logic setup;
  logic strobe;
  // Setup phase and count strobe decode
  assign setup = psel && !penable;
  assign strobe = setup && pwrite && paddr == 32'h1A4 && read_reference_clock;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_ready_next: assert property (setup |=> pready)
    else $error("no answer after setup");
  a_ready_once: assert property (pready |=> !pready)
    else $error("pready held");
  a_unmapped_err: assert property (setup && !pwrite && paddr[11:8] == 4'h3
    |=> pslverr && pslverr_ok(prdata)) else $error("unmapped read not refused");
  a_count_step: assert property (strobe |=> sector_count == $past(sector_count) + 8'h01)
    else $error("sector count missed strobe");
  a_count_hold: assert property (!strobe |=> $stable(sector_count))
    else $error("sector count moved");
  a_status_live: assert property (setup && !pwrite && paddr == 32'h1A4
    |=> prdata[2] == $past(host_reset_in) && prdata[7:4] == 4'h0) else $error("status bits");
  a_hap_halted: assert property (!host_transfer_active && !psel
    |=> $stable(host_address_pointer)) else $error("host pointer moved while halted");
  a_hap_step: assert property (host_transfer_active && host_step && !psel
    |=> host_address_pointer == $past(host_address_pointer) + 16'h1) else $error("no step");
  a_we_drive: assert property (!buffer_we_n |-> buffer_wdata_oe_n == 8'h00)
    else $error("write data not driven");
  // Zero read data on refusal
  function automatic logic pslverr_ok(input logic [31:0] v);
    return v == 32'h0;
  endfunction : pslverr_ok
endmodule : bsp_checker
bind bsp_top bsp_checker u_chk (.*);
`default_nettype wire

// [bsp_buffer_model.sv]
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------
// Buffer memory with pulled switches
// ------------------------------------
module bsp_buffer_model (
  input wire logic clk,
  input wire logic [15:0] buffer_addr,
  input wire logic [7:0] buffer_wdata,
  input wire logic buffer_we_n,
  input wire logic buffer_output_enable_n,
  input wire logic [7:0] switches,
  output logic [7:0] buffer_rdata
);
  logic [7:0] mem [0:255];
  // Store byte at the pointer on strobe
  always_ff @(posedge clk) begin
    if (!buffer_we_n) begin
      mem[buffer_addr[7:0]] <= buffer_wdata;
    end
  end
  // Memory drives when enabled, else pulled switch levels
  assign buffer_rdata = buffer_output_enable_n ? switches : mem[buffer_addr[7:0]];
endmodule : bsp_buffer_model
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam logic [31:0] SH = 32'h178, SL = 32'h17C, SD = 32'h1A0, SS = 32'h1A4;
  localparam logic [31:0] CT = 32'h200, PT = 32'h204, ST = 32'h208;
  logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic host_step = 0, id_end_of_track = 0, id_defect = 0, host_reset_in = 0;
  logic read_reference_clock = 0, host_transfer_active, buffer_we_n, buffer_output_enable_n;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rd, m;
  logic [15:0] host_address_pointer, buffer_addr;
  logic [7:0] buffer_wdata, buffer_wdata_oe_n, buffer_rdata, sector_count, d0, d1, c;
  logic [7:0] switches = 0;
  logic [31:0] eq[$], mq[$];
  int fails = 0, n_tests = 0, seed = 32'h1E0C;
  // ------------------------------------
  // Clock, design and buffer memory
  // ------------------------------------
  always #5 clk = ~clk;
  bsp_top u_dut (.*);
  bsp_buffer_model u_mem (.*);
  // Compare seen and expected
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] t=%0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  // Counts and verdict
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  // Bus transfer; a read notes expected data and mask
  task automatic apb(input logic w, input logic [31:0] a, d, mk = 32'hFF);
    int i;
    if (!w) begin
      eq.push_back(d);
      mq.push_back(mk);
    end
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) penable <= 1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready) break;
    end
    if (i == 20) begin
      fails++;
      complete_run;
    end
    rd = prdata;
    psel <= 0;
    penable <= 0;
  endtask : apb
  // Poll byte ready under a bound
  task automatic wait_rdy;
    for (int k = 0; k < 30; k++) begin
      apb(0, ST, 0, 0);
      if (rd[7]) return;
    end
    fails++;
    complete_run;
  endtask : wait_rdy
  // Watcher compares each read with the oldest note
  always @(posedge clk) if (psel && penable && pready && !pwrite) begin
    m = mq.pop_front();
    chk(prdata & m, eq.pop_front() & m);
  end
  // ------------------------------------
  // Scenarios
  // ------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    resetn <= 1;
    apb(0, SH, 32'h01);
    apb(0, SL, 32'hFF);
    apb(0, SS, 32'h00);
    apb(0, SD, 32'h00);
    $display("reset values done");
    d0 = 8'($random(seed));
    d1 = 8'($random(seed));
    switches <= 8'($random(seed));
    apb(1, CT, 32'h02);
    apb(1, PT, 32'h10);
    wait_rdy;
    apb(1, SD, {24'h0, d0});
    wait_rdy;
    apb(1, SD, {24'h0, d1});
    wait_rdy;
    apb(1, PT, 32'h10);
    apb(0, SD, {24'h0, d1});
    wait_rdy;
    apb(0, SD, {24'h0, d0});
    wait_rdy;
    apb(1, CT, 32'h06);
    repeat (300) @(posedge clk);
    apb(0, SD, {24'h0, d1});
    wait_rdy;
    apb(0, SD, {24'h0, switches});
    $display("scheduled access done");
    apb(1, CT, 32'h02);
    apb(1, SH, 32'h00);
    apb(1, SL, 32'h03);
    apb(1, CT, 32'h0A);
    repeat (10) @(posedge clk) host_step <= ~host_step;
    apb(0, ST, 32'h01, 32'h01);
    apb(0, PT, 32'h30000, 32'hFFFF0000);
    apb(1, SH, 32'h01);
    repeat (4) @(posedge clk) host_step <= ~host_step;
    apb(0, ST, 32'h00, 32'h01);
    apb(0, PT, 32'h50000, 32'hFFFF0000);
    apb(1, CT, 32'h2A);
    apb(0, SH, 32'h01);
    apb(0, SL, 32'hFF);
    apb(0, PT, 32'h0, 32'hFFFF0000);
    $display("stop pointer done");
    @(posedge clk) {id_end_of_track, id_defect, host_reset_in} <= 3'h7;
    @(posedge clk) {id_end_of_track, id_defect} <= 2'h0;
    apb(1, CT, 32'h12);
    apb(0, SS, 32'h0F);
    apb(0, SS, 32'h0C);
    c = sector_count;
    read_reference_clock <= 1;
    repeat (3) apb(1, SS, 0);
    chk({24'h0, sector_count}, {24'h0, c + 8'h03});
    read_reference_clock <= 0;
    apb(1, SS, 0);
    chk({24'h0, sector_count}, {24'h0, c + 8'h03});
    apb(0, 32'h300, 32'h0, 32'hFFFFFFFF);
    $display("sector status done");
    apb(1, SH, 32'h55);
    apb(1, CT, 32'h01);
    apb(0, SH, 32'h01);
    apb(0, SD, 32'h00);
    $display("soft reset done");
    complete_run;
  end
endmodule : tb_top
`default_nettype wire
